// ===== inc/mesc_pkg.sv
package mesc_pkg;

  // ----------------------------------------------------------------
  // register selectors and widths
  // ----------------------------------------------------------------
  localparam int           MESC_ADDR_W   = 12;
  localparam logic [11:0]  MESC_ENV_LO   = 12'h30A;  // environment config, low word / full
  localparam logic [11:0]  MESC_ENV_HI   = 12'h31A;  // environment config high-half alias
  localparam logic [11:0]  MESC_SEC_LO   = 12'h747;  // security config, low word / full
  localparam logic [11:0]  MESC_SEC_HI   = 12'h757;  // security config high-half alias

  // ----------------------------------------------------------------
  // field positions in the 64-bit environment config
  // ----------------------------------------------------------------
  localparam int ENV_LPE_BIT   = 2;
  localparam int ENV_SSE_BIT   = 3;
  localparam int ENV_DTE_BIT   = 59;
  localparam int ENV_CDE_BIT   = 60;
  localparam int ENV_HW_ACCESS_DIRTY_UPDATE_ENABLE_BIT  = 61;
  localparam int ENV_PAGE_ATTR_TYPE_ENABLE_BIT = 62;
  // field position in the 64-bit security config
  localparam int SEC_MACHINE_LANDING_PAD_ENABLE_BIT  = 10;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [63:0] ENV_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] SEC_RESET = 64'h0000_0000_0000_0000;

  // privilege encodings
  localparam logic [1:0] PRIV_USER    = 2'h0;
  localparam logic [1:0] PRIV_SUPER   = 2'h1;
  localparam logic [1:0] PRIV_MACHINE = 2'h3;

  // page permission encoding that becomes reserved without shadow stacks
  localparam logic [2:0] XWR_SHADOW   = 3'h2;

  // register access request from the csr unit
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata_lo;
    logic [31:0] wdata_hi;   // upper word, used only at 64-bit width
    logic [1:0]  priv;
  } mesc_req_t;

  // per-instruction feature queries from the pipeline
  typedef struct packed {
    logic [1:0] priv;
    logic       is_landing_pad_instr;
    logic       is_ss_swap;
    logic       is_ss_mop;
    logic [2:0] pte_xwr;
    logic       pte_vs_s_stage;
  } mesc_query_t;

  // feature enables seen by the rest of the hart
  typedef struct packed {
    logic ad_hw_update_s;
    logic ad_hw_update_g;
    logic ad_fault_s_g;
    logic henv_hw_access_dirty_update_enable_allow;
    logic counter_deleg;
    logic lp_check_active;
    logic landing_pad_instr_is_nop;
    logic elp_hold_none;
    logic ss_active;
    logic ss_mop_revert;
    logic pte_xwr_reserved;
    logic ss_swap_illegal;
    logic henv_sse_allow;
    logic dbltrp_active;
    logic pbmt_active;
    logic fence_resync;
  } mesc_feat_t;

endpackage

// ===== hw/mesc_top.sv
`timescale 1ns/1ps

// Contract
// - hw_access_dirty_update_enable set and option present: hardware sets accessed/dirty bits in supervisor translation.
// - with hypervisor, hw_access_dirty_update_enable set also enables hardware accessed/dirty update in guest stage.
// - hw_access_dirty_update_enable clear: accessed/dirty bit needing update raises page fault, supervisor and guest.
// - hw_access_dirty_update_enable reads zero if option absent; hypervisor copy zero while machine copy zero.
// - counter delegation enable gates delegation; reads zero when delegation unimplemented.
// - landing pad enable set enforces checks in supervisor, or user without supervisor.
// - landing pad enable clear keeps expected state none and landing_pad_instr is a no-op.
// - shadow stack enable set activates shadow stack in supervisor mode.
// - shadow stack enable clear: shadow stack instructions revert to may-be-operations below machine.
// - shadow stack enable clear makes xwr 010b reserved in supervisor stage tables.
// - shadow stack enable clear makes shadow stack swaps illegal below machine mode.
// - machine shadow stack enable zero forces lower copies of that field to zero.
// - double trap enable zero behaves as if supervisor double trap support absent.
// - at 32-bit width a high alias maps env bits 63:32; absent at 64.
// - without user mode the environment register and alias do not exist.
// - security register optional; when present a 64-bit read/write register.
// - machine landing pad enable set enforces landing pad checks in machine mode.
// - machine landing pad enable clear keeps expected state none, landing_pad_instr no-op, machine mode.
// - only at 32-bit width a high alias maps security bits 63:32.
// - after page attribute enable changes, a full translation fence resynchronizes caches.
// - environment register is 64-bit read/write, accessible from machine mode only; lower-mode accesses are illegal.
// - page attribute enable reads zero when that option absent.
module mesc_top #(
  parameter int NATIVE_WIDTH  = 32,
  parameter bit HAS_USER      = 1'b1,
  parameter bit HAS_SUPER     = 1'b1,
  parameter bit HAS_HYPER     = 1'b1,
  parameter bit HAS_SEC_CFG   = 1'b1,
  parameter bit HAS_ADU       = 1'b1,
  parameter bit HAS_CDELEG    = 1'b1,
  parameter bit HAS_PBMT      = 1'b1,
  parameter bit HAS_LP        = 1'b1,
  parameter bit HAS_SS        = 1'b1,
  parameter bit HAS_DBLTRP    = 1'b1
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire mesc_pkg::mesc_req_t   req,
  input  wire mesc_pkg::mesc_query_t query,
  output logic                    ack,
  output logic                    illegal,
  output logic [31:0]             rdata_lo,
  output logic [31:0]             rdata_hi,
  output mesc_pkg::mesc_feat_t    feat
);
  import mesc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [63:0] env;
    logic [63:0] sec;
    logic        ack;
    logic        illegal;
    logic [31:0] rdata_lo;
    logic [31:0] rdata_hi;
    mesc_feat_t  feat;
  } mesc_state_t;

  mesc_state_t st;
  mesc_state_t next_st;

  // ----------------------------------------------------------------
  // writable masks: only implemented fields hold a value
  // ----------------------------------------------------------------
  function automatic logic [63:0] mesc_env_mask();
    logic [63:0] m;
    m = 64'h0;
    m[ENV_HW_ACCESS_DIRTY_UPDATE_ENABLE_BIT]  = HAS_ADU;
    m[ENV_CDE_BIT]   = HAS_CDELEG;
    m[ENV_PAGE_ATTR_TYPE_ENABLE_BIT] = HAS_PBMT;
    m[ENV_LPE_BIT]   = HAS_LP;
    m[ENV_SSE_BIT]   = HAS_SS;
    m[ENV_DTE_BIT]   = HAS_DBLTRP;
    return m;
  endfunction

  function automatic logic [63:0] mesc_sec_mask();
    logic [63:0] m;
    m = 64'h0;
    m[SEC_MACHINE_LANDING_PAD_ENABLE_BIT] = HAS_LP;
    return m;
  endfunction

  localparam logic [63:0] ENV_MASK = mesc_env_mask();
  localparam logic [63:0] SEC_MASK = mesc_sec_mask();
  localparam bit          IS_32    = (NATIVE_WIDTH == 32);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic sel_env_lo;
  logic sel_env_hi;
  logic sel_sec_lo;
  logic sel_sec_hi;
  logic sel_any;

  always_comb begin
    sel_env_lo = HAS_USER && (req.addr == MESC_ENV_LO);
    sel_env_hi = HAS_USER && IS_32 && (req.addr == MESC_ENV_HI);
    sel_sec_lo = HAS_SEC_CFG && (req.addr == MESC_SEC_LO);
    sel_sec_hi = HAS_SEC_CFG && IS_32 && (req.addr == MESC_SEC_HI);
    sel_any    = sel_env_lo | sel_env_hi | sel_sec_lo | sel_sec_hi;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic        ok;
  logic [63:0] env_w;
  logic [63:0] sec_w;
  logic        lower;
  logic        lp_en;

  always_comb begin
    next_st = st;
    env_w   = st.env;
    sec_w   = st.sec;
    ok      = req.valid && sel_any && (req.priv == PRIV_MACHINE);
    next_st.ack     = req.valid;
    next_st.illegal = req.valid && !ok;

    // writes: full word, low word or high alias
    if (ok && req.write) begin
      if (sel_env_lo) begin
        if (IS_32) begin
          env_w[31:0] = req.wdata_lo;
        end else begin
          env_w = {req.wdata_hi, req.wdata_lo};
        end
      end
      if (sel_env_hi) begin
        env_w[63:32] = req.wdata_lo;
      end
      if (sel_sec_lo) begin
        if (IS_32) begin
          sec_w[31:0] = req.wdata_lo;
        end else begin
          sec_w = {req.wdata_hi, req.wdata_lo};
        end
      end
      if (sel_sec_hi) begin
        sec_w[63:32] = req.wdata_lo;
      end
    end
    next_st.env = env_w & ENV_MASK;
    next_st.sec = sec_w & SEC_MASK;

    // read data, current contents
    next_st.rdata_lo = 32'h0;
    next_st.rdata_hi = 32'h0;
    if (ok && !req.write) begin
      if (sel_env_lo) begin
        next_st.rdata_lo = st.env[31:0];
        next_st.rdata_hi = IS_32 ? 32'h0 : st.env[63:32];
      end
      if (sel_env_hi) begin
        next_st.rdata_lo = st.env[63:32];
      end
      if (sel_sec_lo) begin
        next_st.rdata_lo = st.sec[31:0];
        next_st.rdata_hi = IS_32 ? 32'h0 : st.sec[63:32];
      end
      if (sel_sec_hi) begin
        next_st.rdata_lo = st.sec[63:32];
      end
    end

    // feature enables for the pipeline, registered from stored fields, the query and the current write
    lower = (query.priv != PRIV_MACHINE);
    next_st.feat.ad_hw_update_s  = st.env[ENV_HW_ACCESS_DIRTY_UPDATE_ENABLE_BIT];
    next_st.feat.ad_hw_update_g  = HAS_HYPER && st.env[ENV_HW_ACCESS_DIRTY_UPDATE_ENABLE_BIT];
    next_st.feat.ad_fault_s_g    = !st.env[ENV_HW_ACCESS_DIRTY_UPDATE_ENABLE_BIT];
    next_st.feat.henv_hw_access_dirty_update_enable_allow = HAS_HYPER && st.env[ENV_HW_ACCESS_DIRTY_UPDATE_ENABLE_BIT];
    next_st.feat.counter_deleg   = st.env[ENV_CDE_BIT];
    next_st.feat.pbmt_active     = st.env[ENV_PAGE_ATTR_TYPE_ENABLE_BIT];
    next_st.feat.fence_resync    = ok && req.write && (sel_env_lo || sel_env_hi)
                                   && (env_w[ENV_PAGE_ATTR_TYPE_ENABLE_BIT] != st.env[ENV_PAGE_ATTR_TYPE_ENABLE_BIT]);

    // landing pad: machine uses its own enable, lower modes the env enable
    if (query.priv == PRIV_MACHINE) begin
      lp_en = st.sec[SEC_MACHINE_LANDING_PAD_ENABLE_BIT];
    end else if (HAS_SUPER) begin
      lp_en = st.env[ENV_LPE_BIT] && (query.priv == PRIV_SUPER);
    end else begin
      lp_en = st.env[ENV_LPE_BIT] && (query.priv == PRIV_USER);
    end
    next_st.feat.lp_check_active = lp_en;
    next_st.feat.landing_pad_instr_is_nop     = query.is_landing_pad_instr && !lp_en;
    next_st.feat.elp_hold_none   = !lp_en;

    // shadow stacks
    next_st.feat.ss_active        = st.env[ENV_SSE_BIT] && (query.priv == PRIV_SUPER);
    next_st.feat.ss_mop_revert    = query.is_ss_mop && lower && !st.env[ENV_SSE_BIT];
    next_st.feat.pte_xwr_reserved = query.pte_vs_s_stage && !st.env[ENV_SSE_BIT]
                                    && (query.pte_xwr == XWR_SHADOW);
    next_st.feat.ss_swap_illegal  = query.is_ss_swap && lower && !st.env[ENV_SSE_BIT];
    next_st.feat.henv_sse_allow   = st.env[ENV_SSE_BIT];

    // double trap
    next_st.feat.dbltrp_active    = st.env[ENV_DTE_BIT];

    if (rst) begin
      next_st          = '0;
      next_st.env      = ENV_RESET & ENV_MASK;
      next_st.sec      = SEC_RESET & SEC_MASK;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  // outputs straight from flip-flops
  always_comb begin
    ack      = st.ack;
    illegal  = st.illegal;
    rdata_lo = st.rdata_lo;
    rdata_hi = st.rdata_hi;
    feat     = st.feat;
  end

endmodule

// ===== tb/mesc_top_assertions.sv
`timescale 1ns/1ps
module mesc_top_checker #(
  parameter int NATIVE_WIDTH = 32
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire mesc_pkg::mesc_req_t req,
  input wire logic              ack,
  input wire logic              illegal,
  input wire logic [31:0]       rdata_lo,
  input wire logic [31:0]       rdata_hi,
  input wire mesc_pkg::mesc_feat_t feat
);
  import mesc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // request qualifiers
  logic m_req, mapped;
  assign m_req  = req.valid && req.priv == PRIV_MACHINE;
  assign mapped = req.addr inside {MESC_ENV_LO, MESC_ENV_HI, MESC_SEC_LO, MESC_SEC_HI};
  sequence s_env_wr; m_req && req.write && req.addr == MESC_ENV_LO; endsequence
  sequence s_env_rd; m_req && !req.write && req.addr == MESC_ENV_LO; endsequence
  property p_ack_next; req.valid |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_cause; ack |-> $past(req.valid); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_low_priv; req.valid && req.priv != PRIV_MACHINE |=> illegal && rdata_lo == 0; endproperty
  a_low_priv: assert property (p_low_priv) else $error("low priv accepted");
  property p_unmapped; req.valid && !mapped |=> illegal; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
  property p_legal; m_req && mapped |=> ack && !illegal; endproperty
  a_legal: assert property (p_legal) else $error("legal refused");
  property p_env_rb; s_env_wr ##1 s_env_rd |=> rdata_lo == ($past(req.wdata_lo, 2) & 32'h0000_000C);
  endproperty
  a_env_rb: assert property (p_env_rb) else $error("env readback wrong");
  property p_sec_bits; m_req && !req.write && req.addr == MESC_SEC_LO |=> rdata_lo[9:0] == 0;
  endproperty
  a_sec_bits: assert property (p_sec_bits) else $error("sec reserved bits set");
  property p_ad_excl; !(feat.ad_hw_update_s && feat.ad_fault_s_g); endproperty
  a_ad_excl: assert property (p_ad_excl) else $error("update and fault together");
  property p_lp_excl; !(feat.lp_check_active && feat.landing_pad_instr_is_nop); endproperty
  a_lp_excl: assert property (p_lp_excl) else $error("landing_pad_instr nop while checking");
  // each resync pulse follows a machine write to the environment register
  property p_fence; feat.fence_resync |-> $past(m_req && req.write
    && (req.addr == MESC_ENV_LO || req.addr == MESC_ENV_HI)); endproperty
  a_fence: assert property (p_fence) else $error("fence pulse without write");
endmodule
bind mesc_top mesc_top_checker #(.NATIVE_WIDTH(NATIVE_WIDTH)) u_chk (.mclk(mclk), .rst(rst),
  .req(req), .ack(ack), .illegal(illegal), .rdata_lo(rdata_lo), .rdata_hi(rdata_hi),
  .feat(feat));

// ===== tb/mesc_top_tb.sv
`timescale 1ns/1ps
module mesc_top_tb;
  import mesc_pkg::*;
  typedef struct packed {
    logic        ill;
    logic [31:0] lo;
  } mesc_exp_t;
  logic        mclk, rst, ack, illegal;
  logic [31:0] rdata_lo, rdata_hi, seed, r;
  logic [63:0] env, sec;
  mesc_req_t   req;
  mesc_query_t query;
  mesc_feat_t  feat;
  mesc_exp_t   exp_q[$];
  mesc_exp_t   got;
  logic [11:0] amap [5];
  int          fails, total_checks, n;
  mesc_top u_dut (.mclk(mclk), .rst(rst), .req(req), .query(query), .ack(ack),
    .illegal(illegal), .rdata_lo(rdata_lo), .rdata_hi(rdata_hi), .feat(feat));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one request per cycle, expectation noted from the register model
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] p);
    mesc_exp_t e;
    @(posedge mclk);
    req <= '{1'b1, w, a, d, 32'h0, p};
    e = '{1'b1, 32'h0};
    if (p == PRIV_MACHINE && a != 12'h7FF) begin
      e.ill = 1'b0;
      if (w) begin
        if (a == MESC_ENV_LO) env[31:0] = d & 32'h0000_000C;
        if (a == MESC_ENV_HI) env[63:32] = d & 32'h7800_0000;
        if (a == MESC_SEC_LO) sec[31:0] = d & 32'h0000_0400;
      end else begin
        e.lo = a == MESC_ENV_LO ? env[31:0] : a == MESC_ENV_HI ? env[63:32] :
               a == MESC_SEC_LO ? sec[31:0] : sec[63:32];
      end
    end
    exp_q.push_back(e);
  endtask
  // all enables on or off, then feature outputs for a supervisor and machine query
  task automatic feat_case(input logic on);
    access(1'b1, MESC_ENV_LO, on ? 32'h0000_000C : 32'h0, PRIV_MACHINE);
    access(1'b1, MESC_SEC_LO, on ? 32'h0000_0400 : 32'h0, PRIV_MACHINE);
    access(1'b1, MESC_ENV_HI, on ? 32'h7800_0000 : 32'h0, PRIV_MACHINE);
    @(posedge mclk);
    req <= '0;
    query <= '{PRIV_SUPER, 1'b1, 1'b1, 1'b1, XWR_SHADOW, 1'b1};
    n = 0;
    repeat (4) begin
      @(posedge mclk);
      n += feat.fence_resync;
    end
    check(n, 1);
    check(feat, on ? 16'hDC8E : 16'h2370);
    query.priv <= PRIV_MACHINE;
    repeat (3) @(posedge mclk);
    check({feat.lp_check_active, feat.landing_pad_instr_is_nop, feat.elp_hold_none}, on ? 3'h4 : 3'h3);
  endtask
  // result watcher
  always @(posedge mclk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) check(1, 0);
      else begin
        got = exp_q.pop_front();
        check(illegal, got.ill);
        check(rdata_lo, got.lo);
        check(rdata_hi, 0);
      end
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    query = '0;
    env = '0;
    sec = '0;
    seed = 32'h0000_3863;
    amap = '{MESC_ENV_LO, MESC_ENV_HI, MESC_SEC_LO, MESC_SEC_HI, 12'h7FF};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) access(1'b0, amap[i], 32'h0, PRIV_MACHINE);
    feat_case(1'b1);
    feat_case(1'b0);
    access(1'b1, MESC_ENV_LO, 32'hFFFF_FFFF, PRIV_MACHINE);
    access(1'b0, MESC_ENV_LO, 32'h0, PRIV_MACHINE);
    for (int i = 0; i < 120; i++) begin
      r = rnd();
      access(r[0], amap[r[3:1] % 5], rnd(), r[5:4] == 2'h0 ? r[7:6] : PRIV_MACHINE);
    end
    @(posedge mclk);
    req <= '0;
    n = 0;
    while (exp_q.size() > 0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (exp_q.size() > 0) check(1, 0);
    conclude();
  end
endmodule
